//--- design/lssc_pkg.sv
// constants, types and helpers of the led strobe switch control block
// assumes one 125 MHz clock and a power sequencer that reports rail readiness
//
// Contract
// R1: decode colour select into one closed switch
// R2: per-switch 10-bit current word drives DAC
// R3: open leaving switches before closing new one
// R4: dead time set by register 0x0b
// R5: switch staying closed is never opened
// R6: current linear, 2.47 mA per code step
// R7: software keeps current codes at 0x029 or above
// R8: 4-bit transient current limit value provided
// R9: per-switch enable for transient limiting
// R10: software limits red only, about 10% above
// R11: controller rotates red, green, blue, red
// R12: decoder disabled until all rails enabled
// R13: deglitch colour select for 300 ns
// R14: disabled decoder holds switches open, ignores select
// R15: dead time in oscillator cycles, restartable
`default_nettype none

package lssc_pkg;

   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int unsigned MCLK_PERIOD_PS = 8000;
   localparam int unsigned MCLK_FREQ_KHZ = 125000;
   localparam int unsigned OSC_FREQ_KHZ = 9000;
   // divider rounds down, so the tick runs slightly fast
   localparam int unsigned OSC_DIV = MCLK_FREQ_KHZ / OSC_FREQ_KHZ;
   localparam int unsigned DEGLITCH_NS = 300;
   // least time, rounded up to whole cycles
   localparam int unsigned DEGLITCH_CYC = (DEGLITCH_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;

   // -------------------------------------------------------------
   // register map
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_DEAD_TIME = 8'h0b;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] DEAD_TIME_RESET = 8'h00;
   localparam int unsigned STAT_SW_LSB = 0;
   localparam int unsigned STAT_BUSY_BIT = 3;
   localparam int unsigned STAT_EN_BIT = 4;
   localparam int unsigned STAT_LIMIT_BIT = 5;

   // -------------------------------------------------------------
   // colour codes and current scale
   // -------------------------------------------------------------
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_A = 2'h1;
   localparam logic [1:0] SEL_B = 2'h2;
   localparam logic [1:0] SEL_C = 2'h3;
   localparam int unsigned FULL_SCALE_MA = 2528;
   localparam logic [7:0] STEP_CENTI_MA = 8'hf7;

   typedef enum logic [1:0] {
      ST_OFF,
      ST_STEADY,
      ST_BREAK,
      ST_MAKE
   } lssc_state_t;

   function automatic logic [2:0] lssc_decode(input logic [1:0] sel);
      logic [2:0] sw;
      sw = 3'h0;
      unique case (sel)
         SEL_NONE: sw = 3'h0;
         SEL_A: sw = 3'h1;
         SEL_B: sw = 3'h2;
         SEL_C: sw = 3'h4;
      endcase
      return sw;
   endfunction : lssc_decode

   function automatic logic [17:0] lssc_centi_ma(input logic [9:0] code);
      logic [17:0] prod;
      prod = 18'({8'h00, code} * {10'h000, STEP_CENTI_MA});
      return prod;
   endfunction : lssc_centi_ma

endpackage : lssc_pkg

`default_nettype wire

//--- design/lssc_deglitch.sv
// colour select carrier and the synchroniser plus deglitch filter for it
// assumes select pins are asynchronous to mclk
`default_nettype none

interface lssc_sel_if;
   logic [1:0] sel;
   modport src (output sel);
   modport dst (input sel);
endinterface : lssc_sel_if

module lssc_deglitch
   import lssc_pkg::*;
#(
   parameter int unsigned FILTER_CYC = lssc_pkg::DEGLITCH_CYC
)
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [1:0] pin_sel,
   lssc_sel_if.src out
);
   localparam int unsigned CW = $clog2(FILTER_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(FILTER_CYC - 1);

   logic [1:0] sync_a;
   logic [1:0] sync_b;
   logic [1:0] cand;
   logic [CW-1:0] cnt;
   logic [1:0] stable;

   // -------------------------------------------------------------
   // two-flop synchroniser
   // -------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         sync_a <= 2'h0;
         sync_b <= 2'h0;
      end
      else
      begin
         sync_a <= pin_sel;
         sync_b <= sync_a;
      end
   end

   // -------------------------------------------------------------
   // filter: a new code must hold for the whole window
   // -------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         cand <= 2'h0;
         cnt <= '0;
         stable <= 2'h0;
      end
      else if (sync_b != cand)
      begin
         cand <= sync_b;
         cnt <= '0;
      end
      else if (cnt == LAST)
      begin
         stable <= cand; // see R13
      end
      else
      begin
         cnt <= cnt + CW'(1);
      end
   end

   assign out.sel = stable;

endmodule : lssc_deglitch

`default_nettype wire

//--- design/lssc_top.sv
// strobe decoder: colour select to cathode switches, DAC word and limit
// assumes rails_ready and all word inputs come from mclk-domain logic
`default_nettype none

module lssc_top
   import lssc_pkg::*;
#(
   parameter int unsigned FILTER_CYC = lssc_pkg::DEGLITCH_CYC,
   parameter int unsigned TICK_DIV = lssc_pkg::OSC_DIV
)
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic colour_select_bit0,
   input wire logic colour_select_bit1,
   input wire logic rails_ready,
   input wire logic [9:0] current_word_a,
   input wire logic [9:0] current_word_b,
   input wire logic [9:0] current_word_c,
   input wire logic [3:0] transient_limit_value,
   input wire logic [2:0] transient_limit_enable,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic cathode_switch_a,
   output logic cathode_switch_b,
   output logic cathode_switch_c,
   output logic [9:0] dac_word,
   output logic dac_valid,
   output logic [17:0] dac_setpoint_centi_ma,
   output logic limit_active,
   output logic [3:0] limit_value,
   output logic strobe_enabled
);
   import lssc_pkg::*;

   localparam int unsigned TW = $clog2(TICK_DIV + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_DIV - 1);

   lssc_sel_if sel_bus ();

   logic [7:0] switch_dead_time;
   logic [TW-1:0] tick_cnt;
   logic osc_tick;
   lssc_state_t state;
   logic [1:0] target;
   logic [2:0] sw;
   logic [7:0] dead_cnt;
   logic [9:0] next_dac_word;
   logic next_dac_valid;
   logic sel_changed;

   // -------------------------------------------------------------
   // colour select deglitch
   // -------------------------------------------------------------
   lssc_deglitch #(
      .FILTER_CYC(FILTER_CYC)
   ) u_deglitch (
      .mclk(mclk),
      .reset_n(reset_n),
      .pin_sel({colour_select_bit1, colour_select_bit0}),
      .out(sel_bus)
   );

   // -------------------------------------------------------------
   // register port
   // -------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         switch_dead_time <= DEAD_TIME_RESET;
      end
      else if (reg_wr_en && reg_addr == ADDR_DEAD_TIME)
      begin
         switch_dead_time <= reg_wdata; // see R4
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         reg_rdata <= 8'h00;
      end
      else if (reg_rd_en)
      begin
         if (reg_addr == ADDR_DEAD_TIME)
         begin
            reg_rdata <= switch_dead_time;
         end
         else if (reg_addr == ADDR_STATUS)
         begin
            reg_rdata <= 8'h00;
            reg_rdata[STAT_SW_LSB +: 3] <= sw;
            reg_rdata[STAT_BUSY_BIT] <= (state == ST_BREAK) || (state == ST_MAKE);
            reg_rdata[STAT_EN_BIT] <= (state != ST_OFF);
            reg_rdata[STAT_LIMIT_BIT] <= limit_active;
         end
         else
         begin
            reg_rdata <= 8'h00;
         end
      end
   end

   // -------------------------------------------------------------
   // oscillator-rate tick
   // -------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         tick_cnt <= '0;
         osc_tick <= 1'b0;
      end
      else if (tick_cnt == TICK_LAST)
      begin
         tick_cnt <= '0;
         osc_tick <= 1'b1;
      end
      else
      begin
         tick_cnt <= tick_cnt + TW'(1);
         osc_tick <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // break-before-make sequencer
   // -------------------------------------------------------------
   assign sel_changed = (sel_bus.sel != target);

   // dead time jitters by up to one tick period, since ticks are free-running
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         state <= ST_OFF;
         target <= SEL_NONE;
         sw <= 3'h0;
         dead_cnt <= 8'h00;
      end
      else if (!rails_ready)
      begin
         state <= ST_OFF; // see R12
         target <= SEL_NONE; // see R14
         sw <= 3'h0; // see R14
         dead_cnt <= 8'h00;
      end
      else
      begin
         unique case (state)
            ST_OFF:
            begin
               state <= ST_STEADY;
            end
            ST_STEADY:
            begin
               if (sel_changed)
               begin
                  target <= sel_bus.sel;
                  sw <= sw & lssc_decode(sel_bus.sel); // see R3, R5
                  dead_cnt <= switch_dead_time; // see R4
                  state <= ST_BREAK;
               end
            end
            ST_BREAK:
            begin
               if (sel_changed)
               begin
                  target <= sel_bus.sel; // see R15
                  sw <= sw & lssc_decode(sel_bus.sel); // see R5
                  dead_cnt <= switch_dead_time; // see R15
               end
               else if (dead_cnt == 8'h00)
               begin
                  state <= ST_MAKE;
               end
               else if (osc_tick)
               begin
                  dead_cnt <= dead_cnt - 8'h01; // see R15
               end
            end
            ST_MAKE:
            begin
               sw <= lssc_decode(target); // see R1, R3
               state <= ST_STEADY;
            end
         endcase
      end
   end

   assign cathode_switch_a = sw[0];
   assign cathode_switch_b = sw[1];
   assign cathode_switch_c = sw[2];
   assign strobe_enabled = (state != ST_OFF);

   // -------------------------------------------------------------
   // current DAC word follows the closed switch
   // -------------------------------------------------------------
   always_comb
   begin
      next_dac_word = 10'h000;
      next_dac_valid = 1'b1;
      if (sw[0])
      begin
         next_dac_word = current_word_a; // see R2
      end
      else if (sw[1])
      begin
         next_dac_word = current_word_b; // see R2
      end
      else if (sw[2])
      begin
         next_dac_word = current_word_c; // see R2
      end
      else
      begin
         next_dac_valid = 1'b0; // see R1
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         dac_word <= 10'h000;
         dac_valid <= 1'b0;
         dac_setpoint_centi_ma <= 18'h00000;
      end
      else
      begin
         dac_word <= next_dac_word;
         dac_valid <= next_dac_valid;
         dac_setpoint_centi_ma <= lssc_centi_ma(next_dac_word); // see R6
      end
   end

   // -------------------------------------------------------------
   // transient current limit
   // -------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         limit_active <= 1'b0;
         limit_value <= 4'h0;
      end
      else
      begin
         limit_active <= |(sw & transient_limit_enable); // see R9
         limit_value <= transient_limit_value; // see R8
      end
   end

endmodule : lssc_top

`default_nettype wire

//--- tb/lssc_top_chk.sv
// port-level assertions for the strobe decoder
// assumes one mclk domain with a synchronous active-low reset
`default_nettype none

module lssc_top_chk
#(
   parameter int unsigned FILTER_CYC = lssc_pkg::DEGLITCH_CYC,
   parameter int unsigned TICK_DIV = lssc_pkg::OSC_DIV
)
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic rails_ready,
   input wire logic [9:0] current_word_a,
   input wire logic [3:0] transient_limit_value,
   input wire logic [2:0] transient_limit_enable,
   input wire logic cathode_switch_a,
   input wire logic cathode_switch_b,
   input wire logic cathode_switch_c,
   input wire logic [9:0] dac_word,
   input wire logic dac_valid,
   input wire logic [17:0] dac_setpoint_centi_ma,
   input wire logic limit_active,
   input wire logic [3:0] limit_value,
   input wire logic strobe_enabled
);
   timeunit 1ns;
   timeprecision 1ps;

   wire logic [2:0] sw = {cathode_switch_c, cathode_switch_b, cathode_switch_a};
   wire logic lim_now = |(sw & transient_limit_enable);

   default clocking @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   property p_one_closed;
      $onehot0(sw);
   endproperty
   a_one_closed: assert property (p_one_closed) else $error("two switches closed");
   property p_word_a;
      cathode_switch_a |=> dac_word == $past(current_word_a);
   endproperty
   a_word_a: assert property (p_word_a) else $error("dac word not from switch a");
   property p_no_word;
      sw == 3'h0 |=> !dac_valid && dac_word == 10'h000;
   endproperty
   a_no_word: assert property (p_no_word) else $error("dac active with all open");
   property p_break_first;
      |(sw & ~$past(sw)) |-> $past(sw) == 3'h0;
   endproperty
   a_break_first: assert property (p_break_first) else $error("switch closed before break");
   property p_scale;
      dac_setpoint_centi_ma == 18'(dac_word) * 18'h000f7;
   endproperty
   a_scale: assert property (p_scale) else $error("setpoint not linear in word");
   property p_rails_down;
      !rails_ready |=> sw == 3'h0 && !strobe_enabled;
   endproperty
   a_rails_down: assert property (p_rails_down) else $error("decoder live without rails");
   property p_limit_value;
      1'b1 |=> limit_value == $past(transient_limit_value);
   endproperty
   a_limit_value: assert property (p_limit_value) else $error("limit value not copied");
   property p_limit_on;
      1'b1 |=> limit_active == $past(lim_now);
   endproperty
   a_limit_on: assert property (p_limit_on) else $error("limit enable mismatch");
endmodule : lssc_top_chk

bind lssc_top lssc_top_chk #(.FILTER_CYC(FILTER_CYC), .TICK_DIV(TICK_DIV)) lssc_top_chk_inst (.mclk, .reset_n,
   .rails_ready, .current_word_a, .transient_limit_value, .transient_limit_enable, .cathode_switch_a,
   .cathode_switch_b, .cathode_switch_c, .dac_word, .dac_valid, .dac_setpoint_centi_ma, .limit_active,
   .limit_value, .strobe_enabled);

`default_nettype wire

//--- tb/lssc_ctrl_model.sv
// display controller model driving the two colour select pins
// assumes the caller picks the code order
`default_nettype none

module lssc_ctrl_model
(
   input wire logic mclk,
   output logic colour_select_bit0,
   output logic colour_select_bit1
);
   timeunit 1ns;
   timeprecision 1ps;

   initial {colour_select_bit1, colour_select_bit0} = 2'h0;

   // pins change only just after an edge, as a real controller would
   task automatic show(input logic [1:0] code);
      @(posedge mclk);
      {colour_select_bit1, colour_select_bit0} <= code;
   endtask : show
endmodule : lssc_ctrl_model

`default_nettype wire

//--- tb/tb_top.sv
// testbench: register access, select decoding, dead time and rail gating
// assumes lssc_ctrl_model drives the select pins
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; \
   $display("unexpected t=%0t got %h exp %h", $time, a, e); end end

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import lssc_pkg::*;
   // short filter and tick keep the run brief
   localparam int unsigned FC = 4;
   localparam int unsigned TD = 2;
   logic mclk, reset_n, colour_select_bit0, colour_select_bit1, rails_ready, reg_wr_en, reg_rd_en;
   logic [9:0] current_word_a, current_word_b, current_word_c, dac_word;
   logic [3:0] transient_limit_value, limit_value;
   logic [2:0] transient_limit_enable;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic cathode_switch_a, cathode_switch_b, cathode_switch_c, dac_valid, limit_active, strobe_enabled;
   logic [17:0] dac_setpoint_centi_ma;
   wire logic [2:0] sw = {cathode_switch_c, cathode_switch_b, cathode_switch_a};
   logic [7:0] dt [2] = '{8'h00, 8'h14};
   int error_cnt = 0;
   int comparisons = 0;
   int gap;

   lssc_top #(.FILTER_CYC(FC), .TICK_DIV(TD)) lssc_top_inst (.mclk, .reset_n, .colour_select_bit0,
      .colour_select_bit1, .rails_ready, .current_word_a, .current_word_b, .current_word_c,
      .transient_limit_value, .transient_limit_enable, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
      .reg_rdata, .cathode_switch_a, .cathode_switch_b, .cathode_switch_c, .dac_word, .dac_valid,
      .dac_setpoint_centi_ma, .limit_active, .limit_value, .strobe_enabled);
   lssc_ctrl_model lssc_ctrl_model_inst (.mclk, .colour_select_bit0, .colour_select_bit1);

   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic wrap_up();
      if (error_cnt == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up

   // checks sample at the falling edge, clear of the update edge
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask : tick

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr_en <= 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_rd_en <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd_en <= 1'b0;
      tick(2);
      `CHK(reg_rdata, e)
   endtask : rd_chk

   task automatic wait_sw(input logic [2:0] e, output int n);
      n = 0;
      do
      begin
         @(negedge mclk);
         n++;
      end while (sw !== e && n < 400);
      if (sw !== e)
      begin
         error_cnt++;
         wrap_up();
      end
   endtask : wait_sw

   initial
   begin
      reset_n = 1'b0;
      rails_ready = 1'b0;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      current_word_a = 10'h029;
      current_word_b = 10'h200;
      current_word_c = 10'h3ff;
      transient_limit_value = 4'h9;
      transient_limit_enable = 3'h1;
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      rd_chk(8'h0b, 8'h00);
      rd_chk(8'h40, 8'h00);
      lssc_ctrl_model_inst.show(SEL_A);
      tick(60);
      `CHK(sw, 3'h0)
      `CHK(strobe_enabled, 1'b0)
      @(posedge mclk);
      rails_ready <= 1'b1;
      wait_sw(3'h1, gap);
      tick(2);
      `CHK(dac_word, current_word_a)
      `CHK(dac_setpoint_centi_ma, 18'h0278f)
      `CHK(limit_active, 1'b1)
      `CHK(limit_value, 4'h9)
      `CHK(dac_valid, 1'b1)
      // status: switch a closed, enabled, idle, limiting
      rd_chk(8'h0c, 8'h31);
      // pulse shorter than the filter must not move anything, not even briefly
      lssc_ctrl_model_inst.show(SEL_B);
      tick(2);
      lssc_ctrl_model_inst.show(SEL_A);
      repeat (30)
      begin
         tick(1);
         `CHK(sw, 3'h1)
      end
      for (int k = 0; k < 2; k++)
      begin
         wr(8'h0b, dt[k]);
         rd_chk(8'h0b, dt[k]);
         lssc_ctrl_model_inst.show(k ? SEL_C : SEL_B);
         wait_sw(3'h0, gap);
         wait_sw(k ? 3'h4 : 3'h2, gap);
         `CHK(gap >= dt[k] * TD && gap <= dt[k] * TD + TD + 4, 1'b1)
         tick(2);
         `CHK(dac_word, k ? current_word_c : current_word_b)
      end
      lssc_ctrl_model_inst.show(SEL_A);
      wait_sw(3'h0, gap);
      tick(10);
      lssc_ctrl_model_inst.show(SEL_B);
      wait_sw(3'h2, gap);
      `CHK(gap >= 40 && gap <= 40 + TD + FC + 12, 1'b1)
      lssc_ctrl_model_inst.show(SEL_NONE);
      wait_sw(3'h0, gap);
      tick(2);
      `CHK(dac_valid, 1'b0)
      lssc_ctrl_model_inst.show(SEL_C);
      wait_sw(3'h4, gap);
      @(posedge mclk);
      rails_ready <= 1'b0;
      tick(2);
      `CHK(sw, 3'h0)
      `CHK(strobe_enabled, 1'b0)
      wrap_up();
   end
endmodule : tb_top

`undef CHK
`default_nettype wire
